// ### tcth_pkg.sv
// constants, register map and types for the thermometer and thermostat block
package tcth_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int CONV_TIME_MS = 750;
	localparam int CONV_CYCLES = CLK_HZ / 1000 * CONV_TIME_MS;
	localparam int TW = 9;
	localparam int CW = 8;
	localparam logic [11:0] A_CMD = 12'h000;
	localparam logic [11:0] A_CFG = 12'h004;
	localparam logic [11:0] A_TEMP = 12'h008;
	localparam logic [11:0] A_HIGH = 12'h00C;
	localparam logic [11:0] A_LOW = 12'h010;
	localparam logic [11:0] A_COUNT = 12'h014;
	localparam logic [11:0] A_SLOPE = 12'h018;
	localparam logic [11:0] A_STAT = 12'h01C;
	localparam logic [1:0] CMD_START = 2'h1;
	localparam logic [1:0] CMD_STOP = 2'h2;
	localparam int CFG_ONESHOT = 0;
	localparam int CFG_POL = 1;
	localparam int CFG_LOWF = 5;
	localparam int CFG_HIGHF = 6;
	localparam int CFG_DONE = 7;
	localparam logic [TW-1:0] HIGH_RST = 9'h0FA;
	localparam logic [TW-1:0] LOW_RST = 9'h0F0;
	localparam logic [CW-1:0] SLOPE_RST = 8'h10;
	localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
	typedef enum logic [1:0] {TCTH_IDLE, TCTH_CONV} tcth_state_t;
	// 16-bit image of a 9-bit half-degree word
	function automatic logic [15:0] tcth_img(input logic [TW-1:0] t);
		tcth_img = {t, 7'h00}; // whole-degree byte on top
	endfunction
endpackage

// ### tcth_conv.sv
// conversion sequencer: continuous or one-shot timing of conversions
module tcth_conv
	import tcth_pkg::*;
#(
	parameter int CYC = CONV_CYCLES
) (
	input wire logic i_clk_sys, // clock
	input wire logic i_rstn, // sync reset, low
	input wire logic i_start, // begin pulse
	input wire logic i_stop, // halt pulse
	input wire logic i_one_shot, // mode select
	output logic o_busy, // converting
	output logic o_done // conversion end pulse
);
	typedef struct packed {
		tcth_state_t st;
		logic [31:0] cnt;
		logic done;
	} tcth_conv_st_t;
	tcth_conv_st_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		unique case (s_q.st)
			TCTH_IDLE: begin
				if (i_start) begin
					s_d.st = TCTH_CONV;
					s_d.cnt = 32'h0000_0000;
				end
			end
			TCTH_CONV: begin
				s_d.cnt = s_q.cnt + 32'h0000_0001;
				if (i_stop) begin
					// rewind so a halt on the last count cannot overrun
					s_d.st = TCTH_IDLE;
					s_d.cnt = 32'h0000_0000;
				end else if (s_q.cnt == 32'(CYC - 1)) begin
					s_d.done = 1'b1;
					s_d.cnt = 32'h0000_0000;
					if (i_one_shot) s_d.st = TCTH_IDLE;
				end
			end
			default: s_d.st = TCTH_IDLE;
		endcase
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) s_q <= '0;
		else s_q <= s_d;
	end
	assign o_busy = (s_q.st == TCTH_CONV);
	assign o_done = s_q.done;
	conv_bound_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_q.cnt < 32'(CYC)) else $error("conversion overran");
	// mode is judged as it stood when the end of conversion was decided
	oneshot_idle_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(o_done && $past(i_one_shot)) |-> !o_busy)
		else $error("one-shot did not idle");
	stop_idle_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(o_busy && i_stop) |=> !o_busy) else $error("halt ignored");
	cont_go_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(o_done && !$past(i_one_shot) && !$past(i_stop)) |-> o_busy)
		else $error("continuous stopped");
endmodule

// ### tcth_tstat.sv
// thermostat hysteresis and output polarity
module tcth_tstat
	import tcth_pkg::*;
(
	input wire logic i_clk_sys, // clock
	input wire logic i_rstn, // sync reset, low
	input wire logic i_done, // conversion end pulse
	input wire logic [TW-1:0] i_temp, // new result
	input wire logic [TW-1:0] i_high, // high threshold
	input wire logic [TW-1:0] i_low, // low threshold
	input wire logic i_pol, // 1 active high
	output logic o_active, // internal alarm
	output logic o_tout // thermostat pin
);
	typedef struct packed {
		logic act;
	} tcth_ts_st_t;
	tcth_ts_st_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		if (i_done) begin
			// signed compare, same format as result
			if ($signed(i_temp) >= $signed(i_high)) s_d.act = 1'b1;
			else if ($signed(i_temp) < $signed(i_low)) s_d.act = 1'b0;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) s_q <= '0;
		else s_q <= s_d;
	end
	assign o_active = s_q.act;
	assign o_tout = s_q.act ~^ i_pol;
	only_on_done_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		!$past(i_done) |-> $stable(o_active))
		else $error("thermostat moved without conversion");
	trip_high_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_done && $signed(i_temp) >= $signed(i_high)) |=> o_active)
		else $error("did not trip high");
	release_low_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_done && $signed(i_temp) < $signed(i_low) &&
		$signed(i_temp) < $signed(i_high)) |=> !o_active)
		else $error("did not release below low");
	band_hold_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_done && $signed(i_temp) >= $signed(i_low) &&
		$signed(i_temp) < $signed(i_high)) |=> o_active == $past(o_active))
		else $error("hysteresis band not held");
	pol_level_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		o_tout == (i_pol ? o_active : !o_active))
		else $error("polarity wrong");
endmodule

// ### tcth_top.sv
// thermometer and thermostat core with apb register access
// Overview of operation
// - result is 9-bit half-degree two's complement
// - result bytes shifted msb first
// - sixteen-bit image, 7D00h is +125
// - one or two bytes; low byte half-bit
// - range -55 to +125, half-degree steps
// - counter and slope readable for refinement
// - idle after power-up until begin command
// - continuous converts until halt command
// - begin restarts after halt anytime
// - one-shot: one conversion then idle
// - mode chosen by single-conversion select
// - thermostat updates only at conversion end
// - active at >= high, clears below low
// - active level chosen by polarity bit
// - thresholds kept nonvolatile; here reset reloads HIGH_RST and LOW_RST
// - thresholds share result format
// - conversion ends within one second
// - done bit one when finished
// - polarity one high, zero low, nonvolatile; here reset sets it to one
// - one-shot output holds last state
//
// Decided for this implementation: the register offsets and register access over APB.
module tcth_top
	import tcth_pkg::*;
#(
	parameter int CYC = CONV_CYCLES
) (
	input wire logic i_clk_sys, // 40 MHz clock
	input wire logic i_rstn, // sync reset, low
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic i_pwrite, // apb direction
	input wire logic [11:0] i_paddr, // apb byte address
	input wire logic [31:0] i_pwdata, // apb write data
	output logic [31:0] o_prdata, // apb read data
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error
	input wire logic [tcth_pkg::TW-1:0] i_sense, // sensed temperature word
	input wire logic [tcth_pkg::CW-1:0] i_residual, // sensed residual count
	output logic o_tout // thermostat output
);
	typedef struct packed {
		logic [TW-1:0] temp;
		logic [CW-1:0] count;
		logic [CW-1:0] slope;
		logic [TW-1:0] high;
		logic [TW-1:0] low;
		logic output_polarity_bit;
		logic one_shot;
		logic done;
		logic highf;
		logic lowf;
		logic [31:0] rdata;
	} tcth_top_st_t;
	tcth_top_st_t s_q, s_d;
	logic busy, cdone, act, wr, rd, start, stop, hit;
	logic [31:0] rmux;
	// write strobe aimed at one register
	function automatic logic sel_wr(input logic w, input logic [11:0] a,
		input logic [11:0] r);
		sel_wr = w && (a == r);
	endfunction
	assign wr = i_psel && i_penable && i_pwrite;
	assign rd = i_psel && !i_penable && !i_pwrite;
	assign start = sel_wr(wr, i_paddr, A_CMD) && i_pwdata[1:0] == CMD_START;
	assign stop = sel_wr(wr, i_paddr, A_CMD) && i_pwdata[1:0] == CMD_STOP;
	tcth_conv #(.CYC(CYC)) u_conv (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_start(start),
		.i_stop(stop),
		.i_one_shot(s_q.one_shot),
		.o_busy(busy),
		.o_done(cdone)
	);
	tcth_tstat u_tstat (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_done(cdone),
		// judge the word latched at this end, not the one before it
		.i_temp(i_sense),
		.i_high(s_q.high),
		.i_low(s_q.low),
		.i_pol(s_q.output_polarity_bit),
		.o_active(act),
		.o_tout(o_tout)
	);
	always_comb begin
		hit = 1'b1;
		rmux = BAD_ADDR_DATA;
		unique case (i_paddr)
			A_CMD: rmux = BAD_ADDR_DATA;
			A_CFG: begin
				rmux[CFG_DONE] = s_q.done;
				rmux[CFG_HIGHF] = s_q.highf;
				rmux[CFG_LOWF] = s_q.lowf;
				rmux[CFG_POL] = s_q.output_polarity_bit;
				rmux[CFG_ONESHOT] = s_q.one_shot;
			end
			A_TEMP: rmux = {16'h0000, tcth_img(s_q.temp)};
			A_HIGH: rmux = {16'h0000, tcth_img(s_q.high)};
			A_LOW: rmux = {16'h0000, tcth_img(s_q.low)};
			A_COUNT: rmux = {24'h00_0000, s_q.count};
			A_SLOPE: rmux = {24'h00_0000, s_q.slope};
			A_STAT: rmux = {31'h0000_0000, act};
			default: hit = 1'b0;
		endcase
	end
	always_comb begin
		s_d = s_q;
		if (rd) s_d.rdata = rmux;
		// thresholds only change on write or reset, which reloads HIGH_RST and LOW_RST
		if (sel_wr(wr, i_paddr, A_HIGH)) begin
			s_d.high = i_pwdata[15:7];
		end
		if (sel_wr(wr, i_paddr, A_LOW)) begin
			s_d.low = i_pwdata[15:7];
		end
		if (sel_wr(wr, i_paddr, A_CFG)) begin
			s_d.output_polarity_bit = i_pwdata[CFG_POL];
			s_d.one_shot = i_pwdata[CFG_ONESHOT];
			if (!i_pwdata[CFG_HIGHF]) s_d.highf = 1'b0;
			if (!i_pwdata[CFG_LOWF]) s_d.lowf = 1'b0;
		end
		if (start) s_d.done = 1'b0;
		if (cdone) begin
			// latch new result; holds through idle
			s_d.temp = i_sense;
			s_d.count = i_residual;
			s_d.done = 1'b1;
		end
		// flag set wins over a simultaneous clear
		if (cdone && $signed(i_sense) >= $signed(s_q.high)) s_d.highf = 1'b1;
		if (cdone && $signed(i_sense) <= $signed(s_q.low)) s_d.lowf = 1'b1;
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			s_q <= '0;
			s_q.high <= HIGH_RST;
			s_q.low <= LOW_RST;
			s_q.slope <= SLOPE_RST;
			s_q.output_polarity_bit <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end
	// reads prepared in setup, so access phase is one cycle
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !hit;
	assign o_prdata = s_q.rdata;
	idle_boot_a: assert property (
		@(posedge i_clk_sys)
		!i_rstn |=> !busy) else $error("not idle after reset");
	boot_quiet_a: assert property (
		@(posedge i_clk_sys)
		!i_rstn |=> (!act && !s_q.done && !o_tout))
		else $error("alarm or done set after reset");
	hold_temp_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		!$past(cdone) |-> $stable(s_q.temp))
		else $error("result changed without conversion");
	temp_latch_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		cdone |=> s_q.temp == $past(i_sense))
		else $error("result not latched");
	count_latch_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		cdone |=> s_q.count == $past(i_residual))
		else $error("residual not latched");
	slope_const_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		$stable(s_q.slope)) else $error("slope moved");
	done_bit_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		cdone |=> s_q.done) else $error("done bit not set");
	start_clr_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(start && !cdone) |=> !s_q.done) else $error("done not cleared");
	wr_high_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		sel_wr(wr, i_paddr, A_HIGH) |=> s_q.high == $past(i_pwdata[15:7]))
		else $error("high threshold write lost");
	wr_low_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		sel_wr(wr, i_paddr, A_LOW) |=> s_q.low == $past(i_pwdata[15:7]))
		else $error("low threshold write lost");
	thr_hold_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		!$past(wr) |-> ($stable(s_q.high) && $stable(s_q.low)))
		else $error("threshold moved without write");
	cfg_wr_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		sel_wr(wr, i_paddr, A_CFG) |=>
		(s_q.output_polarity_bit == $past(i_pwdata[CFG_POL]) &&
		s_q.one_shot == $past(i_pwdata[CFG_ONESHOT])))
		else $error("mode bits not written");
	highf_set_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(cdone && $signed(i_sense) >= $signed(s_q.high)) |=> s_q.highf)
		else $error("high flag not set");
	lowf_set_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(cdone && $signed(i_sense) <= $signed(s_q.low)) |=> s_q.lowf)
		else $error("low flag not set");
	img_fmt_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(rd && i_paddr == A_TEMP) |=> o_prdata[6:0] == 7'h00)
		else $error("low bits not zero");
	cv_conv_c: cover property (@(posedge i_clk_sys) disable iff (!i_rstn) cdone);
	cv_trip_c: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
		$rose(act));
	cv_stop_c: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
		busy && stop);
	cv_oneshot_c: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
		cdone && s_q.one_shot);
endmodule

// ### tcth_sense_model.sv
// sensor front-end model: holds the word that the next conversion samples
module tcth_sense_model
	import tcth_pkg::*;
(
	input wire logic i_clk_sys, // clock
	input wire logic [tcth_pkg::TW-1:0] i_set, // temperature to present
	output logic [tcth_pkg::TW-1:0] o_sense, // sensed word
	output logic [tcth_pkg::CW-1:0] o_residual // residual count
);
	timeunit 1ns;
	timeprecision 1ps;
	// residual derived from the low eight bits of the word, so it follows the word
	always_ff @(posedge i_clk_sys) begin
		o_sense <= i_set;
		o_residual <= i_set[7:0] ^ 8'h5A;
	end
endmodule

// ### tcth_top_bench.sv
// self-checking bench for the thermometer and thermostat core over apb
module tcth_top_bench;
	import tcth_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int C = 20;
	logic i_clk_sys = 0, i_rstn = 0, psel = 0, pen = 0, pwr = 0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h0000_0000, rd, prdata;
	logic pready, pslverr, tout, err;
	logic [TW-1:0] set = 9'h000, sense;
	logic [CW-1:0] resid;
	int miscompares = 0, samples_checked = 0;
	tcth_sense_model u_tcth_sense_model (.i_clk_sys(i_clk_sys),
		.i_set(set), .o_sense(sense), .o_residual(resid));
	tcth_top #(.CYC(C)) u_tcth_top (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr),
		.i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_sense(sense), .i_residual(resid),
		.o_tout(tout));
	initial begin
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end
	function automatic logic [31:0] img(input logic [TW-1:0] t);
		img = {16'h0000, t, 7'h00};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge i_clk_sys);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge i_clk_sys);
		pen <= 1;
		@(posedge i_clk_sys);
		// wait ends when ready is seen; the watchdog ends a wait that never sees it
		while (pready !== 1'b1) begin
			@(posedge i_clk_sys);
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		pen <= 0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task automatic go(input logic [1:0] c, input int cyc);
		apb(1, A_CMD, {30'h0000_0000, c});
		repeat (cyc) @(posedge i_clk_sys);
	endtask
	task automatic close_out;
		$display("checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge i_clk_sys);
		miscompares++;
		close_out;
	end
	initial begin
		repeat (6) @(posedge i_clk_sys);
		i_rstn <= 1;
		rchk(A_HIGH, 32'h0000_7D00);
		rchk(A_LOW, 32'h0000_7800);
		rchk(A_SLOPE, 32'h0000_0010);
		rchk(A_CFG, 32'h0000_0002);
		rchk(12'h020, 32'h0000_0000);
		chk(err, 1'b1);
		chk(tout, 1'b0);
		$display("test reset done");
		repeat (3 * C) @(posedge i_clk_sys);
		rchk(A_TEMP, 32'h0000_0000);
		rchk(A_STAT, 32'h0000_0000);
		$display("test idle done");
		apb(1, A_CFG, 32'h0000_0003);
		set <= 9'h0FA;
		go(CMD_START, C + 5);
		rchk(A_TEMP, 32'h0000_7D00);
		rchk(A_COUNT, 32'h0000_00A0);
		chk(tout, 1'b1);
		rchk(A_STAT, 32'h0000_0001);
		// done, high flag, polarity and one-shot all set
		rchk(A_CFG, 32'h0000_00C3);
		set <= 9'h192;
		repeat (3 * C) @(posedge i_clk_sys);
		rchk(A_TEMP, 32'h0000_7D00);
		chk(tout, 1'b1);
		go(CMD_START, C + 5);
		rchk(A_TEMP, 32'h0000_C900);
		chk(tout, 1'b0);
		rchk(A_CFG, 32'h0000_00E3);
		$display("test one-shot done");
		apb(1, A_CFG, 32'h0000_0002);
		set <= 9'h0FA;
		go(CMD_START, C + 5);
		chk(tout, 1'b1);
		set <= 9'h0F4;
		repeat (2 * C + 5) @(posedge i_clk_sys);
		rchk(A_TEMP, img(9'h0F4));
		chk(tout, 1'b1);
		set <= 9'h1FF;
		repeat (2 * C + 5) @(posedge i_clk_sys);
		rchk(A_TEMP, 32'h0000_FF80);
		chk(tout, 1'b0);
		apb(1, A_CFG, 32'h0000_0000);
		// polarity lands at the access edge; look one cycle on
		@(posedge i_clk_sys);
		chk(tout, 1'b1);
		go(CMD_STOP, C + 5);
		set <= 9'h032;
		repeat (3 * C) @(posedge i_clk_sys);
		rchk(A_TEMP, 32'h0000_FF80);
		go(CMD_START, C + 5);
		rchk(A_TEMP, 32'h0000_1900);
		chk(tout, 1'b1);
		apb(1, A_LOW, 32'h0000_0C80);
		rchk(A_LOW, 32'h0000_0C80);
		$display("test continuous done");
		close_out;
	end
endmodule
